/* File: verilog/spi_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by bare name; 40 MHz system clock.
// Notes: Definitions only.
`ifndef SPI_PARAMS_SVH
`define SPI_PARAMS_SVH

`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_DATA 12'h008

`define CTL_IRQ_EN 7
`define CTL_PORT_EN 6
`define CTL_MASTER 5
`define CTL_CPOL 4
`define CTL_CPHA 3
`define CTL_RATE_HI 2
`define CTL_RATE_LO 0

`define STA_DONE 7
`define STA_WRITE_COLLISION_FLAG 6
`define STA_OVR 5
`define STA_MASTER_FAULT_FLAG 4
`define STA_SEL_OUT 2
`define STA_SOFT 1
`define STA_LEVEL 0

`define SEL_OUT_RESET 1'b1
`define RATE_MAX 3'h5
`define HALF_BASE 8'h02
`define HALF_MIN 8'h01
`define LAST_EDGE 5'h0F

`endif

/* File: verilog/spi_pkg.sv */
// Purpose: State types of both link ends.
// Assumes: Field defaults come from spi_params.svh.
// Notes: One packed struct per module holds all of its state.
package spi_pkg;

typedef struct packed {
    logic en;
    logic master_select_bit;
    logic ie;
    logic cpol;
    logic cpha;
    logic [2:0] rate;
    logic done;
    logic write_collision_flag;
    logic overrun_flag;
    logic master_fault_flag;
    logic select_soft_manage;
    logic select_internal_level;
    logic sel_out;
    logic done_arm;
    logic master_fault_flag_arm;
    logic busy;
    logic [4:0] edges;
    logic [6:0] div;
    logic sck;
    logic sck_d;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rxbuf;
} dev_state_t;

typedef struct packed {
    logic busy;
    logic sck;
    logic sck_d;
    logic done;
    logic [4:0] edges;
    logic [7:0] div;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rx_out;
} ptn_state_t;

endpackage : spi_pkg

/* File: verilog/spi_link_if.sv */
// Purpose: Four-wire serial link joining the port and its partner.
// Assumes: Bench drives sck_pull to the idle level and one_wire.
// Notes: Pins resolve from output enables; undriven clock takes the pull, undriven data lines read high.
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
    logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
    logic dev_miso_o, dev_miso_oe, dev_sel_out_n;
    logic ptn_sck_o, ptn_sck_oe, ptn_mosi_o, ptn_mosi_oe;
    logic ptn_miso_o, ptn_miso_oe, ptn_sel_n;
    logic sck_pull, one_wire;
    logic sck, mosi_line, miso_line, mosi, miso;

    assign sck = dev_sck_oe ? dev_sck_o : (ptn_sck_oe ? ptn_sck_o : sck_pull);
    assign mosi_line = dev_mosi_oe ? dev_mosi_o :
        (ptn_mosi_oe ? ptn_mosi_o : 1'b1);
    assign miso_line = dev_miso_oe ? dev_miso_o :
        (ptn_miso_oe ? ptn_miso_o : 1'b1);
    // Joined data pins give one shared line: simplex only
    assign mosi = one_wire ? (mosi_line & miso_line) : mosi_line;
    assign miso = one_wire ? (mosi_line & miso_line) : miso_line;

    modport dev_end (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
        dev_miso_o, dev_miso_oe, dev_sel_out_n,
        input sck, mosi, miso, ptn_sel_n);
    modport ptn_end (output ptn_sck_o, ptn_sck_oe, ptn_mosi_o, ptn_mosi_oe,
        ptn_miso_o, ptn_miso_oe, ptn_sel_n,
        input sck, mosi, miso, dev_sel_out_n);
endinterface : spi_link_if
`default_nettype wire

/* File: verilog/spi_partner.sv */
// Purpose: Far end of the link: a plain master or slave byte shifter.
// Assumes: Same clock as the port; inputs synchronous to sys_clk.
// Notes: Master clock half period is half_cycles, never below one.
`timescale 1ns/1ps
`default_nettype none
`include "spi_params.svh"
module spi_partner (
    input wire logic sys_clk,
    input wire logic rst,
    spi_link_if.ptn_end link,
    input wire logic master_mode,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] half_cycles,
    input wire logic select_n,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic done,
    output logic busy
);
    spi_pkg::ptn_state_t s_reg, s_next;
    logic [7:0] half_m1;
    logic selected, edge_hit, lead, sample, din;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.sck_d = link.sck;
        // Faster than sys_clk/2 cannot be seen by the port
        half_m1 = (half_cycles < `HALF_MIN) ? 8'h00 : half_cycles - 8'h01;
        selected = ~master_mode & ~link.dev_sel_out_n;
        edge_hit = 1'b0;
        if (master_mode) begin
            lead = (s_reg.sck == cpol);
            din = link.miso;
            if (start && !s_reg.busy) begin
                s_next.tx = tx_byte;
                s_next.busy = 1'b1;
                s_next.edges = 5'h00;
                s_next.div = half_m1;
            end
            if (s_reg.busy) begin
                if (s_reg.div == 8'h00) begin
                    edge_hit = 1'b1;
                    s_next.sck = ~s_reg.sck;
                    s_next.div = half_m1;
                end else begin
                    s_next.div = s_reg.div - 8'h01;
                end
            end else begin
                s_next.sck = cpol;
            end
        end else begin
            lead = (s_reg.sck_d == cpol);
            din = link.mosi;
            s_next.sck = cpol;
            s_next.busy = selected && (s_reg.edges != 5'h00);
            if (start && !s_reg.busy) begin
                s_next.tx = tx_byte;
            end
            edge_hit = selected && (link.sck != s_reg.sck_d);
            if (!selected) begin
                s_next.edges = 5'h00;
            end
        end
        sample = cpha ? ~lead : lead;
        if (edge_hit) begin
            if (sample) begin
                s_next.rx = {s_reg.rx[6:0], din};
            end else if (!cpha || s_reg.edges != 5'h00) begin
                s_next.tx = {s_reg.tx[6:0], 1'b0};
            end
            s_next.edges = s_reg.edges + 5'h01;
            if (s_reg.edges == `LAST_EDGE) begin
                s_next.edges = 5'h00;
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.rx_out = sample ? {s_reg.rx[6:0], din} : s_reg.rx;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.ptn_sck_o = s_reg.sck;
    assign link.ptn_sck_oe = master_mode;
    assign link.ptn_mosi_o = s_reg.tx[7];
    assign link.ptn_mosi_oe = master_mode;
    assign link.ptn_miso_o = s_reg.tx[7];
    assign link.ptn_miso_oe = selected;
    assign link.ptn_sel_n = select_n;
    assign rx_byte = s_reg.rx_out;
    assign done = s_reg.done;
    assign busy = s_reg.busy;
endmodule : spi_partner
`default_nettype wire

/* File: verilog/spi_port.sv */
// Purpose: Serial port, master or slave, with APB register access.
// Assumes: Link pins synchronous to sys_clk; partner uses same CPOL/CPHA.
// Notes: Registers: control, control/status, data, one word each.
`timescale 1ns/1ps
`default_nettype none
`include "spi_params.svh"
module spi_port (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    spi_link_if.dev_end link
);
    spi_pkg::dev_state_t s_reg, s_next;
    logic acc, ss_int, slv_sel, slv_busy, xfer_busy;
    logic edge_hit, lead, sample, din;
    logic [2:0] rate_c;
    logic [6:0] half_m1;
    logic [7:0] rx_new;
    logic [31:0] rdata;
    logic bad_addr;

    always_comb begin
        s_next = s_reg;
        rdata = 32'h0000_0000;
        bad_addr = 1'b0;
        acc = psel & penable;
        // Pin is ignored while software owns the select
        ss_int = s_reg.select_soft_manage ? s_reg.select_internal_level : link.ptn_sel_n;
        slv_sel = s_reg.en & ~s_reg.master_select_bit & ~ss_int;
        // Phase zero slave counts as busy for the whole selected time
        slv_busy = s_reg.cpha ? (s_reg.edges != 5'h00) : slv_sel;
        xfer_busy = s_reg.master_select_bit ? s_reg.busy : slv_busy;
        rate_c = (s_reg.rate > `RATE_MAX) ? `RATE_MAX : s_reg.rate;
        half_m1 = 7'((`HALF_BASE << rate_c) - 8'h01);

        if (acc) begin
            unique case (paddr)
                `OFS_CONTROL: begin
                    rdata[7:0] = {s_reg.ie, s_reg.en, s_reg.master_select_bit, s_reg.cpol,
                        s_reg.cpha, s_reg.rate};
                    if (pwrite) begin
                        s_next.ie = pwdata[`CTL_IRQ_EN];
                        s_next.cpol = pwdata[`CTL_CPOL];
                        s_next.cpha = pwdata[`CTL_CPHA];
                        s_next.rate = pwdata[`CTL_RATE_HI:`CTL_RATE_LO];
                        // Enable and master are locked while a fault stands
                        if (!s_reg.master_fault_flag || s_reg.master_fault_flag_arm) begin
                            s_next.en = pwdata[`CTL_PORT_EN];
                            s_next.master_select_bit = pwdata[`CTL_MASTER];
                        end
                        if (s_reg.master_fault_flag_arm) begin
                            s_next.master_fault_flag = 1'b0;
                            s_next.master_fault_flag_arm = 1'b0;
                        end
                    end
                end
                `OFS_STATUS: begin
                    rdata[`STA_DONE] = s_reg.done;
                    rdata[`STA_WRITE_COLLISION_FLAG] = s_reg.write_collision_flag;
                    rdata[`STA_OVR] = s_reg.overrun_flag;
                    rdata[`STA_MASTER_FAULT_FLAG] = s_reg.master_fault_flag;
                    rdata[`STA_SEL_OUT] = s_reg.sel_out;
                    rdata[`STA_SOFT] = s_reg.select_soft_manage;
                    rdata[`STA_LEVEL] = s_reg.select_internal_level;
                    if (s_reg.done || s_reg.write_collision_flag) begin
                        s_next.done_arm = 1'b1;
                    end
                    if (pwrite) begin
                        s_next.sel_out = pwdata[`STA_SEL_OUT];
                        s_next.select_soft_manage = pwdata[`STA_SOFT];
                        s_next.select_internal_level = pwdata[`STA_LEVEL];
                    end else begin
                        s_next.overrun_flag = 1'b0;
                        if (s_reg.master_fault_flag) begin
                            s_next.master_fault_flag_arm = 1'b1;
                        end
                    end
                end
                `OFS_DATA: begin
                    rdata[7:0] = s_reg.rxbuf;
                    if (s_reg.done_arm) begin
                        s_next.done = 1'b0;
                        s_next.write_collision_flag = 1'b0;
                        s_next.done_arm = 1'b0;
                    end
                    if (pwrite) begin
                        if (xfer_busy) begin
                            s_next.write_collision_flag = 1'b1;
                        end else if (!s_reg.done || s_reg.done_arm) begin
                            s_next.tx = pwdata[7:0];
                            if (s_reg.en && s_reg.master_select_bit) begin
                                s_next.busy = 1'b1;
                                s_next.edges = 5'h00;
                                s_next.div = half_m1;
                            end
                        end
                    end
                end
                default: begin
                    bad_addr = 1'b1;
                end
            endcase
        end

        // Shift engine
        s_next.sck_d = link.sck;
        edge_hit = 1'b0;
        if (s_reg.master_select_bit) begin
            lead = (s_reg.sck == s_reg.cpol);
            din = link.miso;
            if (s_reg.busy) begin
                if (s_reg.div == 7'h00) begin
                    edge_hit = 1'b1;
                    s_next.sck = ~s_reg.sck;
                    s_next.div = half_m1;
                end else begin
                    s_next.div = s_reg.div - 7'h01;
                end
            end else begin
                // New polarity shows at once, no glitch when enabled
                s_next.sck = s_next.cpol;
            end
        end else begin
            lead = (s_reg.sck_d == s_reg.cpol);
            din = link.mosi;
            s_next.sck = s_next.cpol;
            // Edges seen one per cycle at most, hence sys_clk/2 ceiling
            edge_hit = slv_sel && (link.sck != s_reg.sck_d);
            if (!slv_sel) begin
                s_next.edges = 5'h00;
            end
        end
        sample = s_reg.cpha ? ~lead : lead;
        rx_new = sample ? {s_reg.rx[6:0], din} : s_reg.rx;
        if (edge_hit) begin
            if (sample) begin
                s_next.rx = rx_new;
            end else if (!s_reg.cpha || s_reg.edges != 5'h00) begin
                s_next.tx = {s_reg.tx[6:0], 1'b0};
            end
            s_next.edges = s_reg.edges + 5'h01;
            if (s_reg.edges == `LAST_EDGE) begin
                s_next.edges = 5'h00;
                s_next.busy = 1'b0;
                // Unread byte keeps the buffer; the new one is lost
                if (s_reg.done) begin
                    s_next.overrun_flag = 1'b1;
                end else begin
                    s_next.rxbuf = rx_new;
                    s_next.done = 1'b1;
                end
            end
        end

        // A master must see its select high; low means another master
        if (s_reg.en && s_reg.master_select_bit && !ss_int) begin
            s_next.master_fault_flag = 1'b1;
            s_next.master_fault_flag_arm = 1'b0;
            s_next.en = 1'b0;
            s_next.master_select_bit = 1'b0;
            s_next.busy = 1'b0;
            s_next.edges = 5'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.sel_out <= `SEL_OUT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = rdata;
    assign pready = 1'b1;
    assign pslverr = acc & bad_addr;
    assign irq = s_reg.ie & (s_reg.done | s_reg.master_fault_flag | s_reg.overrun_flag);
    assign link.dev_sck_o = s_reg.sck;
    assign link.dev_sck_oe = s_reg.en & s_reg.master_select_bit;
    assign link.dev_mosi_o = s_reg.tx[7];
    assign link.dev_mosi_oe = s_reg.en & s_reg.master_select_bit;
    assign link.dev_miso_o = s_reg.tx[7];
    assign link.dev_miso_oe = slv_sel;
    assign link.dev_sel_out_n = s_reg.sel_out;
endmodule : spi_port
`default_nettype wire

/* File: bench/spi_master_slave_port_properties.sv */
// Purpose: Concurrent checks on the link between port and partner.
// Assumes: sck_pull is kept equal to the port's clock polarity.
// Notes: Sees only link signals, so mode bits are inferred from enables.
`timescale 1ns/1ps
`default_nettype none
module spi_link_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic dev_sel_out_n,
    input wire logic ptn_sck_oe,
    input wire logic ptn_miso_oe,
    input wire logic ptn_sel_n,
    input wire logic sck_pull
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_one_clock;
        !(dev_sck_oe && ptn_sck_oe);
    endproperty
    a_one_clock: assert property (p_one_clock)
        else $error("two ends drive the clock");
    property p_half_min;
        dev_sck_oe && $past(dev_sck_oe) && $changed(dev_sck_o) |=>
            (!dev_sck_oe || $stable(dev_sck_o));
    endproperty
    a_half_min: assert property (p_half_min)
        else $error("port clock faster than a quarter of sys_clk");
    property p_idle_level;
        $rose(dev_sck_oe) |-> (dev_sck_o == sck_pull);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("port clock not at idle polarity");
    property p_fault_drop;
        dev_sck_oe && !ptn_sel_n |-> ##[1:3] !dev_sck_oe;
    endproperty
    a_fault_drop: assert property (p_fault_drop)
        else $error("master kept driving with select low");
    property p_mosi_master;
        dev_mosi_oe |-> dev_sck_oe;
    endproperty
    a_mosi_master: assert property (p_mosi_master)
        else $error("port drives data out without clock");
    property p_miso_slave;
        dev_miso_oe |-> !dev_sck_oe;
    endproperty
    a_miso_slave: assert property (p_miso_slave)
        else $error("master port drives slave-out line");
    property p_ptn_miso_slave;
        ptn_miso_oe |-> !ptn_sck_oe;
    endproperty
    a_ptn_miso_slave: assert property (p_ptn_miso_slave)
        else $error("master partner drives slave-out line");
    property p_ptn_unselected;
        dev_sel_out_n && $past(dev_sel_out_n) |-> !ptn_miso_oe;
    endproperty
    a_ptn_unselected: assert property (p_ptn_unselected)
        else $error("unselected partner drives slave-out line");
endmodule : spi_link_properties
`default_nettype wire

/* File: bench/spi_master_slave_port_tb.sv */
// Purpose: Self-checking bench for the port facing its partner.
// Assumes: Zero-wait APB; both ends share sys_clk.
// Notes: Random bytes from a fixed seed, corner cases by hand.
`timescale 1ns/1ps
`default_nettype none
`include "spi_params.svh"
module spi_master_slave_port_tb;
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq, err, sck_q = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic master_mode = 1'b0, cpol = 1'b0, cpha = 1'b0, select_n = 1'b1;
    logic start = 1'b0, pdone, pbusy;
    logic [7:0] half_cycles = 8'h01, tx_byte = 8'h00, rx_byte, a, b;
    int n_errors = 0, tests_run = 0, seed = 20799, cyc = 0, last = 0;
    int half_seen = 0, edges = 0, r;
    spi_link_if lk ();
    spi_port i_spi_port (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .link(lk.dev_end));
    spi_partner i_spi_partner (.sys_clk(sys_clk), .rst(rst),
        .link(lk.ptn_end), .master_mode(master_mode), .cpol(cpol),
        .cpha(cpha), .half_cycles(half_cycles), .select_n(select_n),
        .start(start), .tx_byte(tx_byte), .rx_byte(rx_byte), .done(pdone),
        .busy(pbusy));
    spi_link_properties i_spi_link_properties (.sys_clk(sys_clk),
        .rst(rst), .dev_sck_o(lk.dev_sck_o), .dev_sck_oe(lk.dev_sck_oe),
        .dev_mosi_oe(lk.dev_mosi_oe), .dev_miso_oe(lk.dev_miso_oe),
        .dev_sel_out_n(lk.dev_sel_out_n), .ptn_sck_oe(lk.ptn_sck_oe),
        .ptn_miso_oe(lk.ptn_miso_oe), .ptn_sel_n(lk.ptn_sel_n),
        .sck_pull(lk.sck_pull));

    always #12.5 sys_clk = ~sys_clk;

    // Gap between the last two clock toggles gives the half period
    always @(posedge sys_clk) begin
        cyc++;
        if (lk.sck !== sck_q) begin
            half_seen = cyc - last;
            last = cyc;
            edges++;
        end
        sck_q = lk.sck;
    end

    function automatic int half_of(input int rate);
        return 2 << ((rate > 5) ? 5 : rate);
    endfunction : half_of

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Read data is taken settled, ahead of the edge that commits
        @(negedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
            @(negedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic poll;
        rd = 32'h0;
        for (int i = 0; i < 1000 && rd[`STA_DONE] !== 1'b1; i++) begin
            apb(1'b0, `OFS_STATUS, 32'h0);
        end
    endtask : poll

    // Slave partner only loads its byte, so it is given no wait
    task automatic ptn_go(input logic [7:0] d, input int n);
        tx_byte <= d;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        for (int i = 0; i < n && pdone !== 1'b1; i++) @(posedge sys_clk);
        @(posedge sys_clk);
    endtask : ptn_go

    task automatic finish_test;
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        lk.sck_pull = 1'b0;
        lk.one_wire = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, `OFS_CONTROL, 32'h0);
        chk("control reset", rd, 32'h0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status reset", rd, 32'h4);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped error", err, 1'b1);
        // Port as master; pass 5 also collides with a second data write
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `OFS_CONTROL, 32'h0);
            cpol <= m[1];
            cpha <= m[0];
            lk.sck_pull <= m[1];
            r = (m < 4) ? 0 : $unsigned($random(seed)) % 6;
            a = 8'($random(seed));
            b = 8'($random(seed));
            ptn_go(b, 0);
            apb(1'b1, `OFS_STATUS, 32'h0);
            apb(1'b1, `OFS_CONTROL, {24'h0, m[2], 2'b11, m[1:0], r[2:0]});
            edges = 0;
            apb(1'b1, `OFS_DATA, {24'h0, a});
            if (m == 5) apb(1'b1, `OFS_DATA, {24'h0, ~a});
            poll();
            chk("done", rd[`STA_DONE], 1'b1);
            chk("collision", rd[`STA_WRITE_COLLISION_FLAG], m == 5);
            chk("irq", irq, m[2]);
            apb(1'b0, `OFS_DATA, 32'h0);
            chk("master rx", rd, {24'h0, b});
            chk("partner rx", rx_byte, a);
            chk("clock edges", edges, 16);
            chk("half period", half_seen, half_of(r));
            apb(1'b0, `OFS_STATUS, 32'h0);
            chk("flags cleared", rd[7:6], 2'b00);
            apb(1'b1, `OFS_STATUS, 32'h4);
        end
        select_n <= 1'b0;
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("mode fault", rd[`STA_MASTER_FAULT_FLAG], 1'b1);
        apb(1'b0, `OFS_CONTROL, 32'h0);
        chk("fallback", rd[6:5], 2'b00);
        select_n <= 1'b1;
        apb(1'b1, `OFS_CONTROL, 32'h0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("fault cleared", rd[`STA_MASTER_FAULT_FLAG], 1'b0);
        // Port as slave: phase one by soft select, phase zero by pin
        master_mode <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, `OFS_CONTROL, 32'h0);
            cpol <= k[1];
            cpha <= k[0];
            lk.sck_pull <= k[1];
            // The port answers on slave-out one cycle after it sees the edge
            half_cycles <= 8'((k < 2) ? 2 : 2 + $unsigned($random(seed)) % 4);
            a = 8'($random(seed));
            b = 8'($random(seed));
            apb(1'b1, `OFS_STATUS, k[0] ? 32'h6 : 32'h4);
            apb(1'b1, `OFS_CONTROL, {27'h2, k[1:0], 3'h0});
            apb(1'b1, `OFS_DATA, {24'h0, a});
            select_n <= k[0];
            apb(1'b0, `OFS_STATUS, 32'h0);
            chk("no clock no byte", rd[`STA_DONE], 1'b0);
            ptn_go(b, 300);
            poll();
            chk("slave collision", rd[`STA_WRITE_COLLISION_FLAG], 1'b0);
            if (k == 0) begin
                apb(1'b1, `OFS_DATA, 32'h0);
                apb(1'b0, `OFS_STATUS, 32'h0);
                chk("held select", rd[`STA_WRITE_COLLISION_FLAG], 1'b1);
            end
            apb(1'b0, `OFS_DATA, 32'h0);
            chk("slave rx", rd, {24'h0, b});
            chk("master rx", rx_byte, a);
            select_n <= 1'b1;
        end
        // Two bytes without clearing: the first one is kept
        ptn_go(8'h5A, 300);
        ptn_go(8'hA5, 300);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("overrun", rd[`STA_OVR], 1'b1);
        apb(1'b0, `OFS_DATA, 32'h0);
        chk("overrun rx", rd, 32'h5A);
        finish_test();
    end
endmodule : spi_master_slave_port_tb
`default_nettype wire
